//--- core/frst_pkg.sv
// shared constants of the flash reset and status timing host controller
// assumes a 10 MHz controller clock and a 16-bit nor flash in word mode
package frst_pkg;

   // ----------------------------------------------------------------
   // clock and pin timing (times as printed, cycles derived)
   // ----------------------------------------------------------------
   localparam int unsigned CLK_NS        = 100;  // controller clock period
   localparam int unsigned T_RP_NS       = 500;  // least reset pulse
   localparam int unsigned T_READY_NS    = 500;  // reset to ready, idle
   localparam int unsigned T_READY_ALG_NS = 20000; // reset to ready, busy
   localparam int unsigned T_RH_NS       = 50;   // reset high before read
   localparam int unsigned T_BUSY_NS     = 50;   // slowest busy delay
   localparam int unsigned T_RSP_NS      = 4000; // elevated reset setup
   localparam int unsigned T_ACC_NS      = 120;  // slowest access time
   localparam int unsigned T_WP_NS       = 50;   // slowest write pulse
   localparam int unsigned T_WPH_NS      = 20;   // write pulse high
   localparam int unsigned ERASE_TYP_S   = 1;    // typical sector erase
   localparam int unsigned ERASE_MAX_S   = 8;    // worst sector erase
   localparam int unsigned CYC_PER_S     = 1000000000 / CLK_NS;
   localparam int unsigned SYNC_DEPTH    = 2;    // pin synchroniser stages

   localparam int unsigned RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned READY_CYC = (T_READY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned READY_ALG_CYC =
      (T_READY_ALG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RH_CYC    = (T_RH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned BUSY_CYC  = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RSP_CYC   = (T_RSP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RD_CYC    =
      (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_DEPTH;
   localparam int unsigned WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned GAP_CYC   = 1;    // oe or ce high between polls

   // ----------------------------------------------------------------
   // flash pins
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 17;  // word address
   localparam int unsigned DATA_W = 16;
   localparam int unsigned GEN_TOG_POS = 6;  // general_toggle_bit
   localparam int unsigned ES_TOG_POS  = 2;  // erase_suspend_toggle_bit

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] ADDR_OFS  = 8'h04;
   localparam logic [7:0] WDATA_OFS = 8'h08;
   localparam logic [7:0] RDATA_OFS = 8'h0c;
   localparam logic [7:0] STAT_OFS  = 8'h10;
   localparam logic [7:0] IRQS_OFS  = 8'h14;
   localparam logic [7:0] IRQM_OFS  = 8'h18;

   // control fields
   localparam int unsigned OP_LSB   = 0;   // 3-bit operation code
   localparam int unsigned LAST_POS = 4;   // write ends a command sequence
   localparam int unsigned CED_POS  = 5;   // poll delimited by ce as well as oe
   localparam int unsigned VID_POS  = 8;   // elevated reset level
   localparam logic [31:0] CTRL_MASK  = 32'h0000_0137;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // status fields
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_RDY  = 1;
   localparam int unsigned ST_GTOG = 2;
   localparam int unsigned ST_ETOG = 3;
   localparam int unsigned ST_TMO  = 4;
   localparam int unsigned ST_VIDOK = 5;

   // interrupt fields
   localparam int unsigned IRQ_W     = 3;
   localparam int unsigned IRQ_DONE  = 0;
   localparam int unsigned IRQ_TMO   = 1;
   localparam int unsigned IRQ_RDY   = 2;

   // operation codes
   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_READ  = 3'h1,
      OP_WRITE = 3'h2,
      OP_RESET = 3'h3,
      OP_POLL  = 3'h4,
      OP_WAIT  = 3'h5
   } frst_op_type;

endpackage : frst_pkg

//--- core/frst_sync.sv
// two-stage synchroniser for pin inputs
// assumes the input is asynchronous to clk_in; the first stage is read
// by the second stage only
`timescale 1ns/1ps
module frst_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0  // level held during reset
) (
   input  wire logic         clk_in,    // destination clock
   input  wire logic         resetn_in, // async reset, active low
   input  wire logic [W-1:0] d_in,      // asynchronous level
   output logic      [W-1:0] q_out      // synchronised level
);

   logic [W-1:0] meta_reg;  // first stage, metastability catcher

   // ----------------------------------------------------------------
   // two flip-flops in series
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         // reset to the pin's idle level so no false edge follows reset
         meta_reg <= RST_VAL;
         q_out    <= RST_VAL;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end

endmodule : frst_sync

//--- core/frst_host.sv
// host controller that drives a nor flash through its pins
// assumes an apb master on the register side and a flash whose pins are
// asynchronous to ref_clk_in; the testbench resolves the data wire
// Behaviour
// - host waits 50 ns after reset release
// - host may proceed immediately after ready
// - status reads delimited by oe or ce
// - elevated reset held 4 us before write
`timescale 1ns/1ps
module frst_host #(
   parameter int unsigned WAIT_LIMIT_CYC =
      frst_pkg::ERASE_MAX_S * frst_pkg::CYC_PER_S  // ready wait timeout
) (
   input  wire logic        ref_clk_in,       // 10 MHz clock
   input  wire logic        resetn_in,        // async reset, active low
   input  wire logic        psel_in,          // apb select
   input  wire logic        penable_in,       // apb access phase
   input  wire logic        pwrite_in,        // apb direction
   input  wire logic [7:0]  paddr_in,         // apb byte address
   input  wire logic [31:0] pwdata_in,        // apb write data
   output logic      [31:0] prdata_out,       // apb read data
   output logic             pready_out,       // apb ready
   output logic             pslverr_out,      // apb error, unmapped
   output logic             irq_out,          // level interrupt
   output logic [16:0]      flash_addr_out,   // flash word address
   output logic [15:0]      flash_dq_out,     // flash data driven
   output logic             flash_dq_oe_out,  // high while driving data
   input  wire logic [15:0] flash_dq_in,      // flash data seen
   output logic             flash_ce_n_out,   // chip select, active low
   output logic             flash_oe_n_out,   // output enable, active low
   output logic             flash_we_n_out,   // write strobe, active low
   output logic             flash_reset_n_out,// reinit pin, active low
   output logic             flash_vid_en_out, // reinit at elevated level
   input  wire logic        ready_busy_in     // high ready, low busy
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum {
      ST_IDLE, ST_RD, ST_WR_WAIT, ST_WR_LOW, ST_WR_HIGH, ST_BUSY_DLY,
      ST_WAIT_RDY, ST_RST_LOW, ST_RST_HIGH, ST_POLL_A, ST_POLL_GAP,
      ST_POLL_B
   } frst_state_type;

   frst_state_type state_reg, state_next;     // sequencer state
   logic [31:0] cnt_reg, cnt_next;            // shared down counter
   logic [31:0] ctrl_reg;                     // control register
   logic [16:0] addr_reg;                     // flash address register
   logic [15:0] wdata_reg;                    // flash write data
   logic [15:0] rdata_reg, rdata_next;        // last data read
   logic [15:0] first_reg, first_next;        // first poll sample
   logic        gtog_reg, gtog_next;          // general toggle seen
   logic        etog_reg, etog_next;          // suspend toggle seen
   logic        tmo_reg, tmo_next;            // last wait timed out
   logic [7:0]  vid_cnt_reg;                  // elevated level age
   logic [frst_pkg::IRQ_W-1:0] irqs_reg;      // sticky events
   logic [frst_pkg::IRQ_W-1:0] irqm_reg;      // event mask
   logic        rb_prev_reg;                  // ready level, last cycle
   logic        done;                         // operation finished
   logic        tmo_evt;                      // wait timed out
   logic [15:0] dq_sync;                      // synchronised data pins
   logic        rb_sync;                      // synchronised ready level

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   frst_sync #(.W(frst_pkg::DATA_W)) u_dq_sync (
      .clk_in    (ref_clk_in),
      .resetn_in (resetn_in),
      .d_in      (flash_dq_in),
      .q_out     (dq_sync)
   );

   // ready idles high; a zero reset value would fake a ready edge
   frst_sync #(.W(1), .RST_VAL(1'b1)) u_rb_sync (
      .clk_in    (ref_clk_in),
      .resetn_in (resetn_in),
      .d_in      (ready_busy_in),
      .q_out     (rb_sync)
   );

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire setup    = psel_in & ~penable_in;
   wire wr_acc   = psel_in & penable_in & pready_out & pwrite_in;
   wire hit_ctrl = paddr_in == frst_pkg::CTRL_OFS;
   wire hit_addr = paddr_in == frst_pkg::ADDR_OFS;
   wire hit_wdat = paddr_in == frst_pkg::WDATA_OFS;
   wire hit_rdat = paddr_in == frst_pkg::RDATA_OFS;
   wire hit_stat = paddr_in == frst_pkg::STAT_OFS;
   wire hit_irqs = paddr_in == frst_pkg::IRQS_OFS;
   wire hit_irqm = paddr_in == frst_pkg::IRQM_OFS;
   wire hit_any  = hit_ctrl | hit_addr | hit_wdat | hit_rdat | hit_stat |
                   hit_irqs | hit_irqm;
   wire idle     = state_reg == ST_IDLE;
   // a new operation is refused unless the sequencer is idle
   wire go       = wr_acc & hit_ctrl & idle;
   wire [2:0] op = pwdata_in[frst_pkg::OP_LSB +: 3];
   wire vid_on   = ctrl_reg[frst_pkg::VID_POS];
   wire vid_ok   = vid_cnt_reg >= 8'(frst_pkg::RSP_CYC);
   wire ce_delim = ctrl_reg[frst_pkg::CED_POS];
   wire cnt_zero = cnt_reg == 32'h0000_0000;

   wire [31:0] status = {26'h0, vid_ok, tmo_reg, etog_reg, gtog_reg,
                         rb_sync, ~idle};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_reg :
      hit_addr ? {15'h0, addr_reg} :
      hit_wdat ? {16'h0, wdata_reg} :
      hit_rdat ? {16'h0, rdata_reg} :
      hit_stat ? status :
      hit_irqs ? {29'h0, irqs_reg} :
      hit_irqm ? {29'h0, irqm_reg} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_zero ? cnt_reg : cnt_reg - 32'h0000_0001;
      rdata_next = rdata_reg;
      first_next = first_reg;
      gtog_next  = gtog_reg;
      etog_next  = etog_reg;
      tmo_next   = tmo_reg;
      done       = 1'b0;
      tmo_evt    = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (go) begin
               case (op)
                  frst_pkg::OP_READ: begin
                     state_next = ST_RD;
                     cnt_next   = 32'(frst_pkg::RD_CYC - 1);
                  end
                  frst_pkg::OP_WRITE: begin
                     state_next = ST_WR_WAIT;
                  end
                  frst_pkg::OP_RESET: begin
                     // a busy flash needs the long abort window
                     state_next = ST_RST_LOW;
                     cnt_next   = rb_sync ?
                        32'(frst_pkg::READY_CYC - 1) :
                        32'(frst_pkg::READY_ALG_CYC - 1);
                  end
                  frst_pkg::OP_POLL: begin
                     state_next = ST_POLL_A;
                     cnt_next   = 32'(frst_pkg::RD_CYC - 1);
                  end
                  frst_pkg::OP_WAIT: begin
                     state_next = ST_WAIT_RDY;
                     cnt_next   = 32'(WAIT_LIMIT_CYC - 1);
                  end
                  default: begin
                     state_next = ST_IDLE;  // unknown code ignored
                  end
               endcase
            end
         end
         ST_RD: begin
            if (cnt_zero) begin
               rdata_next = dq_sync;
               done       = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_WR_WAIT: begin
            // writes wait until the elevated level has aged enough
            if (!vid_on || vid_ok) begin
               state_next = ST_WR_LOW;
               cnt_next   = 32'(frst_pkg::WP_CYC - 1);
            end
         end
         ST_WR_LOW: begin
            if (cnt_zero) begin
               state_next = ST_WR_HIGH;
               cnt_next   = 32'(frst_pkg::WPH_CYC - 1);
            end
         end
         ST_WR_HIGH: begin
            if (cnt_zero && ctrl_reg[frst_pkg::LAST_POS]) begin
               // give the flash its busy delay before sampling ready
               state_next = ST_BUSY_DLY;
               cnt_next   = 32'(frst_pkg::BUSY_CYC - 1);
            end else if (cnt_zero) begin
               done       = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_BUSY_DLY: begin
            if (cnt_zero) begin
               state_next = ST_WAIT_RDY;
               cnt_next   = 32'(WAIT_LIMIT_CYC - 1);
            end
         end
         ST_WAIT_RDY: begin
            if (rb_sync) begin
               // no recovery delay after ready
               tmo_next   = 1'b0;
               done       = 1'b1;
               state_next = ST_IDLE;
            end else if (cnt_zero) begin
               tmo_next   = 1'b1;
               tmo_evt    = 1'b1;
               done       = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_RST_LOW: begin
            if (cnt_zero) begin
               state_next = ST_RST_HIGH;
               cnt_next   = 32'(frst_pkg::RH_CYC - 1);
            end
         end
         ST_RST_HIGH: begin
            if (cnt_zero) begin
               done       = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_POLL_A: begin
            if (cnt_zero) begin
               first_next = dq_sync;
               state_next = ST_POLL_GAP;
               cnt_next   = 32'(frst_pkg::GAP_CYC - 1);
            end
         end
         ST_POLL_GAP: begin
            // strobe high between the two status reads
            if (cnt_zero) begin
               state_next = ST_POLL_B;
               cnt_next   = 32'(frst_pkg::RD_CYC - 1);
            end
         end
         ST_POLL_B: begin
            if (cnt_zero) begin
               rdata_next = dq_sync;
               gtog_next  = first_reg[frst_pkg::GEN_TOG_POS] ^
                            dq_sync[frst_pkg::GEN_TOG_POS];
               etog_next  = first_reg[frst_pkg::ES_TOG_POS] ^
                            dq_sync[frst_pkg::ES_TOG_POS];
               done       = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // pin levels from the next state, so pins come from flip-flops
   // ----------------------------------------------------------------
   wire rd_n  = state_next == ST_RD || state_next == ST_POLL_A ||
                state_next == ST_POLL_B;
   wire wl_n  = state_next == ST_WR_LOW;
   wire dq_n  = wl_n || state_next == ST_WR_HIGH;
   // with ce delimiting, ce also rises in the gap; oe always does
   wire ce_n  = rd_n || wl_n ||
                (state_next == ST_POLL_GAP && !ce_delim);
   wire rst_n = state_next == ST_RST_LOW;

   wire [frst_pkg::IRQ_W-1:0] irq_set = {rb_sync & ~rb_prev_reg,
                                         tmo_evt, done};
   wire [frst_pkg::IRQ_W-1:0] irq_clr =
      (wr_acc && hit_irqs) ? pwdata_in[frst_pkg::IRQ_W-1:0] : '0;

   // ----------------------------------------------------------------
   // state, counter and result registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 32'h0000_0000;
         rdata_reg <= 16'h0000;
         first_reg <= 16'h0000;
         gtog_reg  <= 1'b0;
         etog_reg  <= 1'b0;
         tmo_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         rdata_reg <= rdata_next;
         first_reg <= first_next;
         gtog_reg  <= gtog_next;
         etog_reg  <= etog_next;
         tmo_reg   <= tmo_next;
      end
   end

   // ----------------------------------------------------------------
   // software registers; set wins over a write-one clear
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_reg    <= frst_pkg::CTRL_RESET;
         addr_reg    <= 17'h0_0000;
         wdata_reg   <= 16'h0000;
         irqs_reg    <= '0;
         irqm_reg    <= '0;
         rb_prev_reg <= 1'b1;  // ready is the idle level
      end else begin
         if (wr_acc && hit_ctrl && idle)
            ctrl_reg <= pwdata_in & frst_pkg::CTRL_MASK;
         if (wr_acc && hit_addr && idle)
            addr_reg <= pwdata_in[16:0];
         if (wr_acc && hit_wdat && idle)
            wdata_reg <= pwdata_in[15:0];
         if (wr_acc && hit_irqm)
            irqm_reg <= pwdata_in[frst_pkg::IRQ_W-1:0];
         irqs_reg    <= (irqs_reg & ~irq_clr) | irq_set;
         rb_prev_reg <= rb_sync;
      end
   end

   // ----------------------------------------------------------------
   // elevated reset age counter, saturating
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         vid_cnt_reg <= 8'h00;
      else if (!flash_vid_en_out)
         vid_cnt_reg <= 8'h00;
      else if (!vid_ok)
         vid_cnt_reg <= vid_cnt_reg + 8'h01;
   end

   // ----------------------------------------------------------------
   // registered outputs: apb answer, interrupt and flash pins
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prdata_out        <= 32'h0000_0000;
         pready_out        <= 1'b0;
         pslverr_out       <= 1'b0;
         irq_out           <= 1'b0;
         flash_addr_out    <= 17'h0_0000;
         flash_dq_out      <= 16'h0000;
         flash_dq_oe_out   <= 1'b0;
         flash_ce_n_out    <= 1'b1;
         flash_oe_n_out    <= 1'b1;
         flash_we_n_out    <= 1'b1;
         flash_reset_n_out <= 1'b1;
         flash_vid_en_out  <= 1'b0;
      end else begin
         // one wait-free access phase after every setup cycle
         prdata_out        <= (setup && !pwrite_in) ? rd_mux : 32'h0;
         pready_out        <= setup;
         pslverr_out       <= setup & ~hit_any;
         irq_out           <= |(irqs_reg & irqm_reg);
         flash_addr_out    <= addr_reg;
         flash_dq_out      <= wdata_reg;
         flash_dq_oe_out   <= dq_n;
         flash_ce_n_out    <= ~ce_n;
         flash_oe_n_out    <= ~rd_n;
         flash_we_n_out    <= ~wl_n;
         flash_reset_n_out <= ~rst_n;
         flash_vid_en_out  <= vid_on & ~rst_n;
      end
   end

endmodule : frst_host

//--- testbench/frst_host_asserts.sv
// checker on the flash pins of frst_host
// assumes one clock domain and is bound to every frst_host instance
`timescale 1ns/1ps
module frst_host_asserts (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic flash_ce_n_out,
   input wire logic flash_oe_n_out,
   input wire logic flash_we_n_out,
   input wire logic flash_reset_n_out,
   input wire logic flash_vid_en_out
);
   // ----------------------------------------
   // helper: cycles the elevated level has stood
   // ----------------------------------------
   logic [5:0] vid_age_reg; // saturates, only >= 40 matters
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         vid_age_reg <= 6'h00;
      else if (!flash_vid_en_out)
         vid_age_reg <= 6'h00;
      else if (vid_age_reg != 6'h3f)
         vid_age_reg <= vid_age_reg + 6'h01;
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // ----------------------------------------
   // pin timing
   // ----------------------------------------
   reset_pulse_a: assert property (
      $fell(flash_reset_n_out) |-> !flash_reset_n_out [*5])
      else $error("reset pulse too short");
   reset_recover_a: assert property (
      $rose(flash_reset_n_out) |-> flash_oe_n_out && flash_ce_n_out)
      else $error("read too soon after reset release");
   read_strobe_a: assert property (
      $fell(flash_oe_n_out) |-> !flash_oe_n_out [*4] ##1 flash_oe_n_out)
      else $error("output enable pulse length wrong");
   vid_setup_a: assert property (
      $fell(flash_we_n_out) && flash_vid_en_out |-> vid_age_reg >= 6'd40)
      else $error("write before elevated level settled");
endmodule : frst_host_asserts

bind frst_host frst_host_asserts i_frst_host_asserts (
   .ref_clk_in       (ref_clk_in),
   .resetn_in        (resetn_in),
   .flash_ce_n_out   (flash_ce_n_out),
   .flash_oe_n_out   (flash_oe_n_out),
   .flash_we_n_out   (flash_we_n_out),
   .flash_reset_n_out(flash_reset_n_out),
   .flash_vid_en_out (flash_vid_en_out)
);

//--- testbench/frst_flash_model.sv
// behavioural nor flash: erase busy, toggle bits, reset abort
// assumes the host drives its pins; erase time is shortened
`timescale 1ns/1ps
module frst_flash_model #(
   parameter int ERASE_NS = 30000 // shortened sector erase
) (
   input  wire logic [16:0] addr_in,
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_out,
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        reset_n_in,
   output logic             ready_busy_out
);
   logic        busy = 1'b0;
   logic        gtog = 1'b0;
   logic        etog = 1'b0;
   logic [4:0]  sect = 5'h00;
   logic [15:0] rd;
   assign rd = busy ? {9'h000, gtog, 3'h0, etog, 2'h0}
                    : addr_in[15:0] ^ 16'h5a5a;
   // released bus shows the inverse so stale data is never trusted
   assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
   assign ready_busy_out = !busy;
   always @(posedge we_n_in) begin
      if (reset_n_in && dq_in === 16'h0030 && !busy) begin
         sect = addr_in[16:12];
         // the zero preprogram pass is folded into the busy time
         #30 busy = 1'b1;
      end
   end
   initial forever begin
      @(posedge busy);
      fork : run
         #(ERASE_NS);
         @(negedge reset_n_in) #1000;
      join_any
      disable run;
      busy = 1'b0;
   end
   // either strobe ends a status read
   always @(posedge (oe_n_in | ce_n_in)) begin
      if (busy) begin
         gtog = !gtog;
         if (addr_in[16:12] == sect) etog = !etog;
      end
   end
endmodule : frst_flash_model

//--- testbench/tb.sv
// self-checking bench for frst_host against a behavioural flash
// assumes the model's short erase and a 500 cycle ready wait limit
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, irq, ce_n, oe_n, we_n, frst, vid;
   logic        dq_oe, rb, e;
   logic [16:0] faddr, a;
   logic [15:0] dq_h, dq_f, dq;
   int          fails = 0;
   int          num_checks = 0;
   assign dq = dq_oe ? dq_h : dq_f; // resolved data wire
   frst_host #(.WAIT_LIMIT_CYC(500)) i_frst_host (.ref_clk_in(clk),
      .resetn_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
      .flash_addr_out(faddr), .flash_dq_out(dq_h), .flash_dq_oe_out(dq_oe),
      .flash_dq_in(dq), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
      .flash_we_n_out(we_n), .flash_reset_n_out(frst),
      .flash_vid_en_out(vid), .ready_busy_in(rb));
   frst_flash_model i_frst_flash_model (.addr_in(faddr), .dq_in(dq),
      .dq_out(dq_f), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
      .reset_n_in(frst), .ready_busy_out(rb));
   function automatic logic [31:0] arr(input logic [16:0] x);
      return {16'h0, x[15:0] ^ 16'h5a5a};
   endfunction : arr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // no answer time assumed: only the watchdog ends a stuck wait
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic op(input logic [31:0] c); // start, wait for idle
      int n;
      apb(1'b1, frst_pkg::CTRL_OFS, c);
      n = 0;
      do begin
         apb(1'b0, frst_pkg::STAT_OFS, 32'h0);
         n++;
      end while (r[frst_pkg::ST_BUSY] !== 1'b0 && n < 2000);
      // a poll limit that runs out counts as a mismatch
      if (r[frst_pkg::ST_BUSY] !== 1'b0) fails++;
   endtask : op
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial forever #50 clk = !clk;
   initial begin #3000000; fails++; tally_and_finish; end
   initial begin
      void'($urandom(12));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, frst_pkg::CTRL_OFS, 32'h0); chk(r, frst_pkg::CTRL_RESET);
      apb(1'b0, 8'h1c, 32'h0); chk({r[30:0], e}, 32'h1);
      repeat (3) begin // array reads at random addresses
         a = $urandom;
         apb(1'b1, frst_pkg::ADDR_OFS, {15'h0, a});
         op(32'h1);
         apb(1'b0, frst_pkg::RDATA_OFS, 32'h0); chk(r, arr(a));
      end
      chk(irq, 1'b0); // masked
      apb(1'b1, frst_pkg::IRQM_OFS, 32'h7);
      apb(1'b1, frst_pkg::WDATA_OFS, 32'h30); // erase confirm word
      op(32'h2);
      op(32'h4); chk(r[3:2], 2'b11);
      apb(1'b1, frst_pkg::ADDR_OFS, {15'h0, ~a[16:12], a[11:0]});
      op(32'h24); chk(r[3:2], 2'b01);
      op(32'h5); chk({r[4], r[1:0]}, 3'b010);
      op(32'h4); chk(r[3:2], 2'b00);
      apb(1'b0, frst_pkg::IRQS_OFS, 32'h0); chk(r[2:0], 3'b101);
      chk(irq, 1'b1);
      apb(1'b1, frst_pkg::IRQS_OFS, 32'h7);
      apb(1'b0, frst_pkg::IRQS_OFS, 32'h0); chk({irq, r[2:0]}, 4'h0);
      op(32'h2); chk(r[1], 1'b0);
      op(32'h3); chk(r[1:0], 2'b10);
      op(32'h3); chk(r[1:0], 2'b10);
      apb(1'b1, frst_pkg::WDATA_OFS, 32'h0);
      // elevated write that ends a sequence, so the ready wait runs too
      op(32'h112);
      chk({vid, r[5], r[4], r[0]}, 4'hc);
      tally_and_finish;
   end
endmodule : tb
